// ### usbn_negotiator.sv
// usbn_negotiator: device end, bus-state detection and auto-negotiation
`timescale 1ns/1ps
module usbn_negotiator #(
    parameter int SUSPEND_CYC  = usbn_pkg::SUSPEND_CYC,
    parameter int WAKE_MAX_CYC = usbn_pkg::WAKE_MAX_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // link to software/host side
    usbn_link_if.dev  lnk,
    // user side status
    output logic      suspended_o,
    output logic      resume_seen_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        usbn_pkg::usbn_neg_type        neg;
        logic [1:0]                    ls_prev;
        logic [usbn_pkg::CNT_W-1:0]    run_cnt;
        logic [usbn_pkg::CNT_W-1:0]    wake_cnt;
        logic                          auto_prev;
        logic                          en_prev;
        logic                          seen_k;
        logic [3:0]                    flags;
        logic                          bedd;
        logic                          nidet;
        logic                          snooze;
        logic [1:0]                    opmode;
        logic                          drive_k;
        logic                          irq;
        logic                          suspended;
        logic                          resume_seen;
    } usbn_dev_type;

    usbn_dev_type st_q;
    usbn_dev_type st_d;

    logic [3:0] set_v;

    always_comb
    begin
        st_d = st_q;
        set_v = 4'h0;
        st_d.ls_prev = lnk.line_state;
        st_d.auto_prev = lnk.auto_negotiation_enable;
        st_d.en_prev = lnk.controller_enable;
        st_d.resume_seen = 1'b0;

        // run-length of the current line state; saturates so each event fires once
        if (lnk.line_state != st_q.ls_prev)
        begin
            st_d.run_cnt = '0;
        end
        else if (st_q.run_cnt != {usbn_pkg::CNT_W{1'b1}})
        begin
            st_d.run_cnt = st_q.run_cnt + 1'b1;
        end

        // ------------------------------------------------------------
        // detection disable bit
        // ------------------------------------------------------------
        if (lnk.bedd_set)
        begin
            st_d.bedd = 1'b1;
        end
        if (lnk.bedd_clr)
        begin
            st_d.bedd = 1'b0;
        end
        if (lnk.controller_enable && !st_q.en_prev)
        begin
            st_d.bedd = 1'b1;
        end
        if (lnk.auto_negotiation_enable && !st_q.auto_prev)
        begin
            st_d.bedd = 1'b0;
        end

        // ------------------------------------------------------------
        // timed bus events
        // ------------------------------------------------------------
        if (!st_q.bedd && lnk.controller_enable && lnk.line_state == usbn_pkg::LS_SE0
            && st_q.ls_prev == usbn_pkg::LS_SE0
            && st_q.run_cnt == usbn_pkg::CNT_W'(usbn_pkg::RESET_CYC - 2))
        begin
            set_v[usbn_pkg::FLAG_RESET] = 1'b1;
        end
        if (!st_q.bedd && lnk.line_state == usbn_pkg::LS_J && st_q.ls_prev == usbn_pkg::LS_J
            && st_q.run_cnt == usbn_pkg::CNT_W'(SUSPEND_CYC - 2))
        begin
            set_v[usbn_pkg::FLAG_SUSPEND] = 1'b1;
        end

        // ------------------------------------------------------------
        // negotiation state machine
        // ------------------------------------------------------------
        case (st_q.neg)
            usbn_pkg::NEG_DISABLE:
            begin
                if (lnk.auto_negotiation_enable)
                begin
                    st_d.neg = usbn_pkg::NEG_NORMAL;
                end
            end
            usbn_pkg::NEG_NORMAL:
            begin
                if (set_v[usbn_pkg::FLAG_SUSPEND])
                begin
                    st_d.neg = usbn_pkg::NEG_IN_SUSPEND;
                    st_d.nidet = 1'b1;
                    st_d.suspended = 1'b1;
                end
            end
            usbn_pkg::NEG_IN_SUSPEND:
            begin
                if (st_q.flags[usbn_pkg::FLAG_NON_IDLE] && !st_q.nidet)
                begin
                    st_d.neg = usbn_pkg::NEG_CHECK;
                end
            end
            usbn_pkg::NEG_CHECK:
            begin
                if (lnk.line_state == usbn_pkg::LS_K)
                begin
                    st_d.neg = usbn_pkg::NEG_NORMAL;
                    st_d.resume_seen = 1'b1;
                    st_d.suspended = 1'b0;
                end
                else if (lnk.line_state == usbn_pkg::LS_SE0)
                begin
                    st_d.neg = usbn_pkg::NEG_NORMAL;
                    set_v[usbn_pkg::FLAG_RESET] = 1'b1;
                    st_d.suspended = 1'b0;
                end
            end
            default:
            begin
                st_d.neg = usbn_pkg::NEG_DISABLE;
            end
        endcase
        if (!lnk.auto_negotiation_enable)
        begin
            st_d.neg = usbn_pkg::NEG_DISABLE;
            st_d.suspended = 1'b0;
        end

        // ------------------------------------------------------------
        // non-idle detection and snooze release
        // ------------------------------------------------------------
        if (lnk.non_idle_detect_clr)
        begin
            st_d.nidet = 1'b0;
        end
        if (st_q.nidet && lnk.line_state != usbn_pkg::LS_J)
        begin
            set_v[usbn_pkg::FLAG_NON_IDLE] = 1'b1;
        end
        if (lnk.snooze_set)
        begin
            st_d.snooze = 1'b1;
        end
        if ((st_q.snooze || st_q.neg == usbn_pkg::NEG_IN_SUSPEND) && lnk.line_state == usbn_pkg::LS_K)
        begin
            st_d.snooze = 1'b0;
            set_v[usbn_pkg::FLAG_NON_IDLE] = 1'b1;
        end

        // ------------------------------------------------------------
        // remote wake-up: K driven while the bit stands, cut at the 15 ms ceiling
        // ------------------------------------------------------------
        if (lnk.opmode_wr)
        begin
            st_d.opmode = lnk.opmode_val;
        end
        if (lnk.wakeup)
        begin
            st_d.opmode = usbn_pkg::OPMODE_RAW;
            if (st_q.wake_cnt != usbn_pkg::CNT_W'(WAKE_MAX_CYC))
            begin
                st_d.wake_cnt = st_q.wake_cnt + 1'b1;
            end
            st_d.drive_k = (st_d.wake_cnt != usbn_pkg::CNT_W'(WAKE_MAX_CYC));
        end
        else
        begin
            st_d.wake_cnt = '0;
            st_d.drive_k = 1'b0;
        end

        // end of host resume: J after K (an EOP SE0 may stand between)
        if (!lnk.idle_detect_enable)
        begin
            st_d.seen_k = 1'b0;
        end
        else if (lnk.line_state == usbn_pkg::LS_K)
        begin
            st_d.seen_k = 1'b1;
        end
        else if (st_q.seen_k && lnk.line_state == usbn_pkg::LS_J)
        begin
            st_d.seen_k = 1'b0;
            set_v[usbn_pkg::FLAG_IDLE] = 1'b1;
        end

        // set wins over a clear in the same cycle
        st_d.flags = (st_q.flags & ~lnk.flag_clr) | set_v;
        st_d.irq = lnk.engine_master_irq_enable && |(st_d.flags & lnk.irq_enable);
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || lnk.controller_soft_reset)
        begin
            // line marked unseen, so the first sampled state after reset starts a full-length run
            st_q <= '{neg: usbn_pkg::NEG_DISABLE, ls_prev: usbn_pkg::LS_NONE, flags: usbn_pkg::FLAGS_RST,
                      opmode: usbn_pkg::OPMODE_NORMAL, default: '0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign lnk.flags                    = st_q.flags;
    assign lnk.bus_event_detect_disable = st_q.bedd;
    assign lnk.non_idle_detect_enable   = st_q.nidet;
    assign lnk.snooze_control           = st_q.snooze;
    assign lnk.operating_mode_field     = st_q.opmode;
    assign lnk.drive_k                  = st_q.drive_k;
    assign lnk.irq                      = st_q.irq;
    assign lnk.neg_state                = st_q.neg;
    assign suspended_o                  = st_q.suspended;
    assign resume_seen_o                = st_q.resume_seen;

endmodule

// ### usbn_pkg.sv
// usbn_pkg: shared constants and types of the bus-state negotiator
package usbn_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ       = 20_000_000;
    localparam int RESET_SE0_NS = 2500;
    localparam int SUSPEND_US   = 3000;
    localparam int WAKE_MAX_US  = 15000;
    localparam int WAKE_HOLD_US = 2000;
    localparam int IDLE_MIN_US  = 5000;
    localparam int ATTACH_US    = 100_000;
    localparam int RESET_CYC    = (RESET_SE0_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SUSPEND_CYC  = SUSPEND_US * (CLK_HZ / 1_000_000) + 1;
    localparam int WAKE_MAX_CYC = WAKE_MAX_US * (CLK_HZ / 1_000_000);
    localparam int WAKE_CYC     = WAKE_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int IDLE_CYC     = IDLE_MIN_US * (CLK_HZ / 1_000_000);
    localparam int ATTACH_CYC   = ATTACH_US * (CLK_HZ / 1_000_000) + 1;
    localparam int CNT_W        = 24;

    // ------------------------------------------------------------
    // line state, operating mode, flag positions
    // ------------------------------------------------------------
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J   = 2'h1;
    localparam logic [1:0] LS_K   = 2'h2;
    localparam logic [1:0] LS_NONE = 2'h3;
    localparam logic [1:0] OPMODE_NORMAL = 2'h0;
    localparam logic [1:0] OPMODE_RAW    = 2'h2;
    localparam int FLAG_RESET    = 0;
    localparam int FLAG_SUSPEND  = 1;
    localparam int FLAG_NON_IDLE = 2;
    localparam int FLAG_IDLE     = 3;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    typedef enum logic [1:0] {
        NEG_DISABLE    = 2'b00,
        NEG_NORMAL     = 2'b01,
        NEG_IN_SUSPEND = 2'b10,
        NEG_CHECK      = 2'b11
    } usbn_neg_type;

    typedef enum logic [2:0] {
        SW_DETACHED = 3'b000,
        SW_SETTLE   = 3'b001,
        SW_WAIT_J   = 3'b010,
        SW_RUN      = 3'b011,
        SW_WAKE     = 3'b100
    } usbn_sw_type;
endpackage

// ### usbn_link_if.sv
// usbn_link_if: control/status bundle between negotiator and its software/host side
`timescale 1ns/1ps
interface usbn_link_if;
    logic [1:0] line_state;
    logic       auto_negotiation_enable;
    logic       bedd_set;
    logic       bedd_clr;
    logic       non_idle_detect_clr;
    logic       wakeup;
    logic       idle_detect_enable;
    logic       controller_enable;
    logic       opmode_wr;
    logic [1:0] opmode_val;
    logic       snooze_set;
    logic       controller_soft_reset;
    logic       vbus_detected;
    logic       usb_clock_enable;
    logic [3:0] irq_enable;
    logic       engine_master_irq_enable;
    logic [3:0] flag_clr;
    logic [3:0] flags;
    logic       bus_event_detect_disable;
    logic       non_idle_detect_enable;
    logic       snooze_control;
    logic [1:0] operating_mode_field;
    logic       drive_k;
    logic       irq;
    logic [1:0] neg_state;

    modport dev (
        input  line_state, auto_negotiation_enable, bedd_set, bedd_clr, non_idle_detect_clr, wakeup,
               idle_detect_enable, controller_enable, opmode_wr, opmode_val, snooze_set,
               controller_soft_reset, vbus_detected, usb_clock_enable, irq_enable,
               engine_master_irq_enable, flag_clr,
        output flags, bus_event_detect_disable, non_idle_detect_enable, snooze_control,
               operating_mode_field, drive_k, irq, neg_state
    );
    modport sw (
        output line_state, auto_negotiation_enable, bedd_set, bedd_clr, non_idle_detect_clr, wakeup,
               idle_detect_enable, controller_enable, opmode_wr, opmode_val, snooze_set,
               controller_soft_reset, vbus_detected, usb_clock_enable, irq_enable,
               engine_master_irq_enable, flag_clr,
        input  flags, bus_event_detect_disable, non_idle_detect_enable, snooze_control,
               operating_mode_field, drive_k, irq, neg_state
    );
endinterface

// ### usbn_sw_end.sv
// usbn_sw_end: far end, the software sequence and upstream line state feed
`timescale 1ns/1ps
module usbn_sw_end #(
    parameter int ATTACH_CYC = usbn_pkg::ATTACH_CYC,
    parameter int IDLE_CYC   = usbn_pkg::IDLE_CYC,
    parameter int WAKE_CYC   = usbn_pkg::WAKE_CYC
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // user side
    input  wire logic       vbus_monitor_input_i,
    input  wire logic [1:0] line_state_i,
    input  wire logic       use_auto_i,
    input  wire logic       wake_req_i,
    input  wire logic       reset_done_i,
    output logic [2:0]      phase_o,
    // link to device end
    usbn_link_if.sw         lnk
);

    typedef struct packed {
        usbn_pkg::usbn_sw_type      ph;
        logic [usbn_pkg::CNT_W-1:0] cnt;
        logic [usbn_pkg::CNT_W-1:0] idle_cnt;
        logic                       auto_en;
        logic                       bedd_set;
        logic                       bedd_clr;
        logic                       nidet_clr;
        logic                       wakeup;
        logic                       jdet;
        logic                       ctl_en;
        logic                       op_wr;
        logic                       snz;
        logic                       attach_bits;
        logic [3:0]                 ie;
        logic [3:0]                 fclr;
    } usbn_sw_state_type;

    usbn_sw_state_type st_q;
    usbn_sw_state_type st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.bedd_set = 1'b0;
        st_d.bedd_clr = 1'b0;
        st_d.nidet_clr = 1'b0;
        st_d.op_wr = 1'b0;
        st_d.snz = 1'b0;
        st_d.fclr = lnk.flags & ~st_q.fclr;
        if (line_state_i != usbn_pkg::LS_J)
        begin
            st_d.idle_cnt = '0;
        end
        else if (st_q.idle_cnt != usbn_pkg::CNT_W'(IDLE_CYC))
        begin
            st_d.idle_cnt = st_q.idle_cnt + 1'b1;
        end
        case (st_q.ph)
            usbn_pkg::SW_DETACHED:
            begin
                if (vbus_monitor_input_i)
                begin
                    st_d.attach_bits = 1'b1;
                    st_d.ie = 4'hF;
                    st_d.cnt = '0;
                    st_d.ph = usbn_pkg::SW_SETTLE;
                end
            end
            usbn_pkg::SW_SETTLE:
            begin
                st_d.cnt = st_q.cnt + 1'b1;
                if (st_q.cnt == usbn_pkg::CNT_W'(ATTACH_CYC - 1))
                begin
                    st_d.ctl_en = 1'b1;
                    st_d.op_wr = 1'b1;
                    st_d.ph = usbn_pkg::SW_WAIT_J;
                end
            end
            usbn_pkg::SW_WAIT_J:
            begin
                if (line_state_i == usbn_pkg::LS_J)
                begin
                    st_d.auto_en = use_auto_i;
                    st_d.ph = usbn_pkg::SW_RUN;
                end
            end
            usbn_pkg::SW_RUN:
            begin
                // detection disable is only ever written with negotiation off
                if (!st_q.auto_en && lnk.flags[usbn_pkg::FLAG_SUSPEND])
                begin
                    st_d.bedd_set = 1'b1;
                    st_d.snz = 1'b1;
                end
                if (!st_q.auto_en && lnk.flags[usbn_pkg::FLAG_RESET])
                begin
                    st_d.bedd_set = 1'b1;
                end
                if (!st_q.auto_en && reset_done_i)
                begin
                    st_d.bedd_clr = 1'b1;
                end
                if (lnk.flags[usbn_pkg::FLAG_NON_IDLE])
                begin
                    st_d.nidet_clr = 1'b1;
                end
                if (lnk.flags[usbn_pkg::FLAG_IDLE])
                begin
                    st_d.jdet = 1'b0;
                end
                if (wake_req_i && st_q.idle_cnt == usbn_pkg::CNT_W'(IDLE_CYC))
                begin
                    st_d.ie[usbn_pkg::FLAG_NON_IDLE] = 1'b0;
                    st_d.wakeup = 1'b1;
                    st_d.cnt = '0;
                    st_d.ph = usbn_pkg::SW_WAKE;
                end
            end
            usbn_pkg::SW_WAKE:
            begin
                st_d.cnt = st_q.cnt + 1'b1;
                if (st_q.cnt == usbn_pkg::CNT_W'(WAKE_CYC - 1))
                begin
                    st_d.wakeup = 1'b0;
                    st_d.nidet_clr = 1'b1;
                    st_d.jdet = !st_q.auto_en;
                    st_d.ie[usbn_pkg::FLAG_NON_IDLE] = 1'b1;
                    st_d.ph = usbn_pkg::SW_RUN;
                end
            end
            default:
            begin
                st_d.ph = usbn_pkg::SW_DETACHED;
            end
        endcase
        if (!vbus_monitor_input_i)
        begin
            st_d = '{ph: usbn_pkg::SW_DETACHED, default: '0};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            st_q <= '{ph: usbn_pkg::SW_DETACHED, default: '0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign phase_o                      = st_q.ph;
    assign lnk.line_state               = line_state_i;
    assign lnk.auto_negotiation_enable  = st_q.auto_en;
    assign lnk.bedd_set                 = st_q.bedd_set;
    assign lnk.bedd_clr                 = st_q.bedd_clr;
    assign lnk.non_idle_detect_clr      = st_q.nidet_clr;
    assign lnk.wakeup                   = st_q.wakeup;
    assign lnk.idle_detect_enable       = st_q.jdet;
    assign lnk.controller_enable        = st_q.ctl_en;
    assign lnk.opmode_wr                = st_q.op_wr;
    assign lnk.opmode_val               = usbn_pkg::OPMODE_NORMAL;
    assign lnk.snooze_set               = st_q.snz;
    assign lnk.controller_soft_reset    = 1'b0;
    assign lnk.vbus_detected            = st_q.attach_bits;
    assign lnk.usb_clock_enable         = st_q.attach_bits;
    assign lnk.irq_enable               = st_q.ie;
    assign lnk.engine_master_irq_enable = st_q.attach_bits;
    assign lnk.flag_clr                 = st_q.fclr;

endmodule

// ### usbn_negotiator_properties.sv
// usbn_checker: timing properties watched on the negotiator link
`timescale 1ns/1ps
module usbn_checker #(
    parameter int SUSPEND_CYC  = 40,
    parameter int WAKE_MAX_CYC = 60
) (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    // link signals
    input wire logic [1:0] line_state,
    input wire logic       auto_negotiation_enable,
    input wire logic       wakeup,
    input wire logic       controller_soft_reset,
    input wire logic       engine_master_irq_enable,
    input wire logic [3:0] flags,
    input wire logic       bus_event_detect_disable,
    input wire logic       non_idle_detect_enable,
    input wire logic [1:0] operating_mode_field,
    input wire logic       drive_k,
    input wire logic       irq,
    input wire logic [1:0] neg_state
);
    // ------------------------------------------------------------
    // run-length counters, counted always so they never undercount the device
    // ------------------------------------------------------------
    logic [23:0] j_run_q;
    logic [23:0] k_run_q;
    always_ff @(posedge clk_i)
    begin
        j_run_q <= (sys_rst_i || line_state != 2'h1) ? 24'h000000 : j_run_q + 24'h000001;
        k_run_q <= (sys_rst_i || !drive_k) ? 24'h000000 : k_run_q + 24'h000001;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || controller_soft_reset);
    sequence enter_suspend;
        $past(neg_state) == 2'h1 ##0 $rose(flags[1]);
    endsequence
    AST_BEDD_CLEAR: assert property ($rose(auto_negotiation_enable) |=> !bus_event_detect_disable)
        else $error("detection disable not cleared by auto-negotiation");
    AST_SUSPEND_TIME: assert property ($rose(flags[1]) |-> j_run_q >= SUSPEND_CYC)
        else $error("suspend flag before idle time elapsed");
    AST_TO_SUSPEND: assert property (enter_suspend |-> neg_state == 2'h2 && non_idle_detect_enable)
        else $error("suspend did not enter in-suspend with detect enabled");
    AST_NON_IDLE: assert property (non_idle_detect_enable && line_state != 2'h1 && $past(line_state) == 2'h1
        |=> flags[2])
        else $error("leaving idle did not raise the non-idle flag");
    AST_CHECK_EVENT: assert property (neg_state == 2'h2 && flags[2] && !non_idle_detect_enable
        |=> neg_state == 2'h3)
        else $error("check-event state not entered");
    AST_WAKE_K: assert property ($rose(wakeup) |=> drive_k && operating_mode_field == 2'h2)
        else $error("wake-up did not drive K in raw mode");
    AST_K_LIMIT: assert property (k_run_q <= WAKE_MAX_CYC)
        else $error("resume K driven too long");
    AST_IRQ_GATE: assert property (!engine_master_irq_enable && !$past(engine_master_irq_enable) |-> !irq)
        else $error("interrupt without master enable");
endmodule

// ### test_usb_bus_state_negotiator.sv
// test_usb_bus_state_negotiator: attach, suspend, resume, reset, wake-up and detach run
`timescale 1ns/1ps
module test_usb_bus_state_negotiator;
    // ------------------------------------------------------------
    // stimulus, observation and counters
    // ------------------------------------------------------------
    logic       clk_i      = 1'b0;
    logic       sys_rst_i  = 1'b1;
    logic       vbus       = 1'b0;
    logic [1:0] line       = 2'h1;
    logic       wake_req   = 1'b0;
    logic       use_auto   = 1'b1;
    logic       reset_done = 1'b0;
    logic       seen_clr   = 1'b0;
    logic [2:0] phase;
    logic       suspended;
    logic       resume_seen;
    logic [7:0] seen       = 8'h00;
    int         mismatches = 0;
    int         compares   = 0;
    always #25 clk_i = ~clk_i;
    usbn_link_if usbn_link_if_i ();
    usbn_negotiator #(.SUSPEND_CYC(40), .WAKE_MAX_CYC(60)) usbn_negotiator_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .lnk(usbn_link_if_i), .suspended_o(suspended), .resume_seen_o(resume_seen));
    usbn_sw_end #(.ATTACH_CYC(20), .IDLE_CYC(50), .WAKE_CYC(10)) usbn_sw_end_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .vbus_monitor_input_i(vbus), .line_state_i(line), .use_auto_i(use_auto), .wake_req_i(wake_req),
        .reset_done_i(reset_done), .phase_o(phase), .lnk(usbn_link_if_i));
    usbn_checker usbn_checker_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .line_state(usbn_link_if_i.line_state), .auto_negotiation_enable(usbn_link_if_i.auto_negotiation_enable),
        .wakeup(usbn_link_if_i.wakeup), .controller_soft_reset(usbn_link_if_i.controller_soft_reset),
        .engine_master_irq_enable(usbn_link_if_i.engine_master_irq_enable), .flags(usbn_link_if_i.flags),
        .bus_event_detect_disable(usbn_link_if_i.bus_event_detect_disable),
        .non_idle_detect_enable(usbn_link_if_i.non_idle_detect_enable),
        .operating_mode_field(usbn_link_if_i.operating_mode_field), .drive_k(usbn_link_if_i.drive_k),
        .irq(usbn_link_if_i.irq), .neg_state(usbn_link_if_i.neg_state));
    // flags are acknowledged by the far end within a cycle, so they are latched here
    always @(posedge clk_i)
        seen <= (seen_clr ? 8'h00 : seen) | {usbn_link_if_i.drive_k, usbn_link_if_i.operating_mode_field == 2'h2,
                        resume_seen,
                        usbn_link_if_i.irq, usbn_link_if_i.flags};
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic hold_line(input logic [1:0] ls, input int n);
        line = ls;
        seen_clr = 1'b1;
        tick(1);
        seen_clr = 1'b0;
        tick(n - 1);
    endtask
    task automatic pulse_done();
        reset_done = 1'b1;
        tick(1);
        reset_done = 1'b0;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        tick(12);
        sys_rst_i = 1'b0;
        vbus = 1'b1;
        tick(30);
        check("phase", 8'h03, phase);
        check("auto enable", 8'h01, usbn_link_if_i.auto_negotiation_enable);
        check("detect disable", 8'h00, usbn_link_if_i.bus_event_detect_disable);
        check("controller enable", 8'h01, usbn_link_if_i.controller_enable);
        check("operating mode", 8'h00, usbn_link_if_i.operating_mode_field);
        hold_line(2'h1, 50);
        check("suspend flag", 8'h01, seen[1]);
        check("interrupt", 8'h01, seen[4]);
        check("state", 8'h02, usbn_link_if_i.neg_state);
        check("non-idle detect", 8'h01, usbn_link_if_i.non_idle_detect_enable);
        check("suspended", 8'h01, suspended);
        hold_line(2'h2, 6);
        check("non-idle flag", 8'h01, seen[2]);
        check("resume seen", 8'h01, seen[5]);
        check("snooze", 8'h00, usbn_link_if_i.snooze_control);
        hold_line(2'h0, 60);
        check("reset flag", 8'h01, seen[0]);
        wake_req = 1'b1;
        hold_line(2'h1, 65);
        check("drive K", 8'h01, seen[7]);
        check("raw mode", 8'h01, seen[6]);
        wake_req = 1'b0;
        vbus = 1'b0;
        tick(3);
        check("detached phase", 8'h00, phase);
        check("auto enable off", 8'h00, usbn_link_if_i.auto_negotiation_enable);
        // manual handling: software sets and clears the detection disable bit; the controller enable edge sets it first
        use_auto = 1'b0;
        vbus = 1'b1;
        tick(30);
        check("manual phase", 8'h03, phase);
        check("attach disable", 8'h01, usbn_link_if_i.bus_event_detect_disable);
        pulse_done();
        hold_line(2'h0, 60);
        check("manual reset flag", 8'h01, seen[0]);
        check("reset disable", 8'h01, usbn_link_if_i.bus_event_detect_disable);
        pulse_done();
        hold_line(2'h1, 50);
        check("manual suspend flag", 8'h01, seen[1]);
        check("suspend disable", 8'h01, usbn_link_if_i.bus_event_detect_disable);
        check("snooze set", 8'h01, usbn_link_if_i.snooze_control);
        hold_line(2'h2, 3);
        check("snooze release", 8'h00, usbn_link_if_i.snooze_control);
        check("manual non-idle flag", 8'h01, seen[2]);
        print_verdict();
    end
    initial
    begin
        repeat (1000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end
endmodule
